// File: src/scl_map.svh
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
// Register byte offsets
`define SCL_OFS_STATUS   8'h00
`define SCL_OFS_CLEAR    8'h04
`define SCL_OFS_ENABLE   8'h08
`define SCL_OFS_CONFIG   8'h0C
`define SCL_OFS_ADDR     8'h10
`define SCL_OFS_CAUSE    8'h14
// Reset values
`define SCL_ADDR_RESET   7'h01
`define SCL_BAUD_RESET   BAUD_9600
`define SCL_PAR_RESET    PAR_NONE
// Status event bits
`define SCL_EV_OK        0
`define SCL_EV_ERR       1
`define SCL_EV_RST       2
`define SCL_EV_CAUSE     3
`define SCL_EV_W         4
// Shutdown cause codes
`define SCL_CAUSE_OVP    8'h01
`define SCL_CAUSE_EMIS   8'h02
`define SCL_CAUSE_POWER  8'h08
`define SCL_CAUSE_ION    8'h20
// Characters
`define SCL_CH_HASH      8'h23
`define SCL_CH_CR        8'h0D
`define SCL_CH_STAR      8'h2A
`define SCL_CH_QUES      8'h3F
`define SCL_CH_USCORE    8'h5F
`define SCL_CH_0         8'h30
`define SCL_CH_9         8'h39
`define SCL_CH_A         8'h41
`define SCL_CH_Z         8'h5A
`define SCL_CH_PLUS      8'h2B
`define SCL_CH_MINUS     8'h2D
`define SCL_CH_DOT       8'h2E
`define SCL_CH_E         8'h45
// Mnemonics and reply texts as ASCII bytes
`define SCL_MN_NOPAR     24'h53504E
`define SCL_MN_ODDPAR    24'h53504F
`define SCL_MN_EVENPAR   24'h535045
`define SCL_MN_KEY       24'h554E4C
`define SCL_MN_TOGGLE    24'h544C55
`define SCL_MN_CAUSE     16'h5253
`define SCL_MN_BAUD      16'h5342
`define SCL_TAIL_OK      64'h50524F474D5F4F4B
`define SCL_TAIL_BAD     64'h53594E54585F4552
`define SCL_TAIL_LOCK    64'h434F4D4D5F455252
`define SCL_TAIL_KEYON   64'h315F554C5F4F4E5F
`define SCL_TAIL_KEYOFF  64'h305F554C5F4F4646
`define SCL_NAME_EMIS    40'h454D495353
// Lengths
`define SCL_REPLY_LEN    4'hD
`define SCL_MN_MAX       2'h3
`define SCL_INT_MAX      3'h5
`define SCL_TEN          17'h0000A
// Decimal baud rates
`define SCL_RATE_1200    17'h004B0
`define SCL_RATE_2400    17'h00960
`define SCL_RATE_4800    17'h012C0
`define SCL_RATE_9600    17'h02580
`define SCL_RATE_19200   17'h04B00
`define SCL_RATE_38400   17'h09600
`endif

// File: src/scl_pkg.sv
package scl_pkg;
  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2} scl_parity_t;
  typedef enum logic [2:0] {BAUD_1200 = 3'h0, BAUD_2400 = 3'h1, BAUD_4800 = 3'h2,
                            BAUD_9600 = 3'h3, BAUD_19200 = 3'h4, BAUD_38400 = 3'h5} scl_baud_t;
  typedef enum logic [2:0] {K_ACCEPT = 3'h0, K_BAD = 3'h1, K_LOCKED = 3'h2,
                            K_KEY_ON = 3'h3, K_KEY_OFF = 3'h4, K_CAUSE = 3'h5} scl_kind_t;
  typedef enum logic [1:0] {P_IDLE = 2'h0, P_ADDR1 = 2'h1, P_ADDR2 = 2'h3, P_BODY = 2'h2} scl_pstate_t;
endpackage

// File: src/scl_reply_tx.sv
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_reply_tx
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Request
  input  wire logic        start,
  input  scl_kind_t        kind,
  input  wire logic [7:0]  code,
  input  wire logic [7:0]  addr_hi,
  input  wire logic [7:0]  addr_lo,
  // Character output
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  output logic             busy
);
  scl_kind_t  kind_q;
  logic [7:0] code_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [3:0] idx;

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'hA) ? 8'(`SCL_CH_0 + n) : 8'(`SCL_CH_A + n - 4'hA);
  endfunction

  // Most severe cause names the reply
  function automatic logic [39:0] cause_name(input logic [7:0] c);
    if (c == 8'h00)
      return "ST_OK";
    else if (|(c & `SCL_CAUSE_ION))
      return "ION_C";
    else if (|(c & `SCL_CAUSE_EMIS))
      return `SCL_NAME_EMIS;
    else if (|(c & `SCL_CAUSE_OVP))
      return "OVPRS";
    else
      return "POWER";
  endfunction

  wire [63:0] tail = (kind_q == K_ACCEPT)  ? `SCL_TAIL_OK :
                     (kind_q == K_LOCKED)  ? `SCL_TAIL_LOCK :
                     (kind_q == K_KEY_ON)  ? `SCL_TAIL_KEYON :
                     (kind_q == K_KEY_OFF) ? `SCL_TAIL_KEYOFF :
                     (kind_q == K_CAUSE)   ? {hex_ch(code_q[7:4]), hex_ch(code_q[3:0]),
                                              `SCL_CH_USCORE, cause_name(code_q)} :
                                             `SCL_TAIL_BAD; // R12 R13
  wire [7:0]  prefix   = (kind_q == K_BAD || kind_q == K_LOCKED) ? `SCL_CH_QUES : `SCL_CH_STAR;
  wire [63:0] tail_sh  = tail << {idx - 4'h4, 3'h0};
  wire [7:0]  next_chr = (idx == 4'h0) ? prefix :
                         (idx == 4'h1) ? hi_q :
                         (idx == 4'h2) ? lo_q :
                         (idx == 4'h3) ? `SCL_CH_USCORE :
                         (idx == 4'hC) ? `SCL_CH_CR : tail_sh[63:56]; // R17
  wire        advance  = busy && (!tx_valid || tx_ready);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      {busy, tx_valid, idx} <= 6'h00;
      tx_data <= 8'h00;
      kind_q  <= K_BAD;
      {code_q, hi_q, lo_q} <= 24'h000000;
    end
    else if (start && !busy)
    begin
      {busy, idx} <= {1'b1, 4'h0};
      kind_q <= kind;
      {code_q, hi_q, lo_q} <= {code, addr_hi, addr_lo};
    end
    else if (advance && idx == `SCL_REPLY_LEN)
      {busy, tx_valid} <= 2'h0;
    else if (advance)
    begin
      tx_data  <= next_chr;
      tx_valid <= 1'b1;
      idx      <= 4'(idx + 4'h1);
    end
endmodule

// File: src/scl_top.sv
// How it works
// [R01] No-parity command selects eight bits, no parity
// [R02] Odd-parity command selects seven bits, odd parity
// [R03] Even-parity command selects seven bits, even parity
// [R04] Host sends key right before link settings
// [R05] Locked setting without key gets locked error
// [R06] Key while not required gets bad-command reply
// [R07] Toggle inverts requirement, replies one or zero
// [R08] Key-required reply means key is mandatory
// [R09] Reset command reinitialises fully, sends nothing; code reloads link format and cause only, keeps key requirement
// [R10] Link settings wait pending until next reset
// [R11] First cause query after power reports 08
// [R12] Cause code is sum of all causes
// [R13] Ion collector failure reports cause 20
// [R14] Values accepted as float or scientific form; code classifies them but baud takes integers only
// [R15] Host puts digit before decimal point
// [R16] Baud command carries decimal rate, is guarded
// [R17] Framed hash, address, mnemonic, carriage return
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_top
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Received characters
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  // Transmitted characters
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // Active link format
  output logic             link_data8,
  output logic             link_par_en,
  output logic             link_par_odd,
  output scl_baud_t        link_baud,
  // Shutdown cause events
  input  wire logic        ovp_fail,
  input  wire logic        emis_fail,
  input  wire logic        ion_fail,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             irq
);
  scl_pstate_t pstate;
  logic [7:0]  addr_hi;
  logic [7:0]  addr_lo;
  logic [7:0]  mn [0:2];
  logic [1:0]  mn_len;
  logic        arg_seen;
  logic        bad;
  logic        key_req;
  logic        armed;
  scl_parity_t pend_par;
  scl_baud_t   pend_baud;
  logic [7:0]  cause;
  logic [6:0]  dev_addr;
  logic [`SCL_EV_W-1:0] status;
  logic [`SCL_EV_W-1:0] enable;
  logic        rep_start;
  scl_kind_t   rep_kind;
  logic [7:0]  rep_code;
  logic        rep_busy;
  logic        arg_int;
  logic        arg_float;
  logic        arg_sci;
  logic [16:0] arg_val;

  function automatic logic is_digit(input logic [7:0] c);
    return c >= `SCL_CH_0 && c <= `SCL_CH_9;
  endfunction

  function automatic logic mn_is(input logic [23:0] want);
    return {mn[0], mn[1], mn[2]} == want;
  endfunction

  function automatic logic [3:0] baud_of(input logic [16:0] r);
    unique case (r)
      `SCL_RATE_1200:  return {1'b1, BAUD_1200};
      `SCL_RATE_2400:  return {1'b1, BAUD_2400};
      `SCL_RATE_4800:  return {1'b1, BAUD_4800};
      `SCL_RATE_9600:  return {1'b1, BAUD_9600};
      `SCL_RATE_19200: return {1'b1, BAUD_19200};
      `SCL_RATE_38400: return {1'b1, BAUD_38400};
      default:         return 4'h0;
    endcase
  endfunction

  // Character classes; replies are half duplex so input is dropped while one is pending or being sent
  wire        rx_take   = rx_valid && !rep_busy && !rep_start;
  wire        is_hash   = rx_data == `SCL_CH_HASH;
  wire        is_cr     = rx_data == `SCL_CH_CR;
  wire        is_letter = rx_data >= `SCL_CH_A && rx_data <= `SCL_CH_Z;
  wire        mn_char   = is_letter && !arg_seen;
  wire        arg_feed  = rx_take && pstate == P_BODY && !is_cr && !is_hash && !mn_char;
  wire        frame_clr = rx_take && is_hash;

  // Address match and mnemonic decode
  wire [6:0]  rx_addr   = 7'({3'h0, addr_hi[3:0]} * 7'h0A + {3'h0, addr_lo[3:0]});
  wire        frame_end = rx_take && pstate == P_BODY && is_cr;
  wire        addr_ok   = frame_end && !bad && is_digit(addr_hi) && is_digit(addr_lo)
                          && rx_addr == dev_addr; // R17
  wire        bare      = addr_ok && !arg_seen;
  wire        select_no_parity_cmd       = bare && mn_is(`SCL_MN_NOPAR);
  wire        select_odd_parity_cmd      = bare && mn_is(`SCL_MN_ODDPAR);
  wire        select_even_parity_cmd     = bare && mn_is(`SCL_MN_EVENPAR);
  wire        comm_settings_key_cmd      = bare && mn_is(`SCL_MN_KEY);
  wire        toggle_key_requirement_cmd = bare && mn_is(`SCL_MN_TOGGLE);
  wire        cmd_rst   = bare && mn_is("RST");
  wire        read_shutdown_cause_cmd    = bare && mn_is({`SCL_MN_CAUSE, 8'h00});
  wire [3:0]  rate      = baud_of(arg_val);
  wire        set_baud_cmd = addr_ok && arg_seen && mn_is({`SCL_MN_BAUD, 8'h00}) && arg_int && rate[3]; // R16
  wire        do_set    = select_no_parity_cmd || select_odd_parity_cmd || select_even_parity_cmd || set_baud_cmd;
  wire        locked    = key_req && !armed; // R04
  wire        set_ok    = do_set && !locked;
  wire        soft_rst  = cmd_rst;

  // Reply selection
  wire        next_rep_start = addr_ok && !cmd_rst; // R09
  wire scl_kind_t next_kind  = do_set  ? (locked ? K_LOCKED : K_ACCEPT) : // R05
                               comm_settings_key_cmd ? (key_req ? K_ACCEPT : K_BAD) : // R06
                               toggle_key_requirement_cmd ? (key_req ? K_KEY_OFF : K_KEY_ON) : // R07 R08
                               read_shutdown_cause_cmd ? K_CAUSE : K_BAD;
  wire scl_parity_t next_par = select_no_parity_cmd ? PAR_NONE :
                               select_odd_parity_cmd ? PAR_ODD :
                               select_even_parity_cmd ? PAR_EVEN : pend_par;

  // Causes accumulate; a report clears, a soft reset restarts at power
  wire [7:0]  cause_ev   = (ovp_fail  ? `SCL_CAUSE_OVP  : 8'h00) |
                           (emis_fail ? `SCL_CAUSE_EMIS : 8'h00) |
                           (ion_fail  ? `SCL_CAUSE_ION  : 8'h00); // R13
  wire [7:0]  next_cause = (read_shutdown_cause_cmd ? 8'h00 : soft_rst ? `SCL_CAUSE_POWER : cause)
                           | cause_ev; // R11 R12

  // Register port decode; set wins over clear
  wire        wr_clr   = wr && addr == `SCL_OFS_CLEAR;
  wire        wr_en    = wr && addr == `SCL_OFS_ENABLE;
  wire        wr_addr  = wr && addr == `SCL_OFS_ADDR;
  wire [`SCL_EV_W-1:0] ev;
  assign ev[`SCL_EV_OK]    = (next_rep_start && (next_kind != K_BAD && next_kind != K_LOCKED)) || soft_rst;
  assign ev[`SCL_EV_ERR]   = next_rep_start && (next_kind == K_BAD || next_kind == K_LOCKED);
  assign ev[`SCL_EV_RST]   = soft_rst;
  assign ev[`SCL_EV_CAUSE] = |cause_ev;
  wire [`SCL_EV_W-1:0] next_status = (status & ~(wr_clr ? wdata[`SCL_EV_W-1:0] : {`SCL_EV_W{1'b0}})) | ev;
  wire [31:0] cfg_word = {20'h00000, armed, key_req, pend_baud, pend_par, link_baud, link_par_en, link_par_odd};
  wire [31:0] rd_mux   = (addr == `SCL_OFS_STATUS) ? {28'h0000000, status} :
                         (addr == `SCL_OFS_ENABLE) ? {28'h0000000, enable} :
                         (addr == `SCL_OFS_CONFIG) ? cfg_word :
                         (addr == `SCL_OFS_ADDR)   ? {25'h0000000, dev_addr} :
                         (addr == `SCL_OFS_CAUSE)  ? {24'h000000, cause} : 32'h00000000;

  // Frame parser
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      pstate <= P_IDLE;
      {addr_hi, addr_lo, mn_len, arg_seen, bad} <= 20'h00000;
      {mn[0], mn[1], mn[2]} <= 24'h000000;
    end
    else if (frame_clr)
    begin
      pstate <= P_ADDR1; // R17
      {mn_len, arg_seen, bad} <= 4'h0;
      {mn[0], mn[1], mn[2]} <= 24'h000000;
    end
    else if (rx_take)
    begin
      unique case (pstate)
        P_IDLE:  pstate <= P_IDLE;
        P_ADDR1: {addr_hi, pstate} <= {rx_data, P_ADDR2};
        P_ADDR2: {addr_lo, pstate} <= {rx_data, P_BODY};
        P_BODY:
        begin
          if (is_cr)
            pstate <= P_IDLE;
          else if (mn_char && mn_len == `SCL_MN_MAX)
            bad <= 1'b1;
          else if (mn_char)
          begin
            mn[mn_len] <= rx_data;
            mn_len     <= 2'(mn_len + 2'h1);
          end
          else
            arg_seen <= 1'b1;
        end
      endcase
    end

  // Command effects; the key must directly precede, so any other well-formed frame to this address drops it
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      {key_req, armed} <= 2'h0;
      pend_par  <= `SCL_PAR_RESET;
      pend_baud <= `SCL_BAUD_RESET;
    end
    else if (addr_ok)
    begin
      armed <= comm_settings_key_cmd && key_req; // R04
      if (toggle_key_requirement_cmd)
        key_req <= !key_req; // R07
      if (set_ok)
        pend_par <= next_par; // R10
      if (set_ok && set_baud_cmd)
        pend_baud <= scl_baud_t'(rate[2:0]); // R16 R10
    end

  // Active link format only moves on reset
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      {link_data8, link_par_en, link_par_odd} <= 3'h4;
      link_baud <= `SCL_BAUD_RESET;
    end
    else if (soft_rst)
    begin
      link_data8   <= pend_par == PAR_NONE; // R01 R09
      link_par_en  <= pend_par != PAR_NONE; // R02 R03
      link_par_odd <= pend_par == PAR_ODD; // R02
      link_baud    <= pend_baud; // R10
    end

  // Reply request and shutdown cause
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      rep_start <= 1'b0;
      rep_kind  <= K_BAD;
      rep_code  <= 8'h00;
      cause     <= `SCL_CAUSE_POWER; // R11
    end
    else
    begin
      rep_start <= next_rep_start;
      cause     <= next_cause;
      if (next_rep_start)
      begin
        rep_kind <= next_kind;
        rep_code <= cause; // R12
      end
    end

  // Software registers
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      {status, enable, irq} <= 9'h000;
      dev_addr <= `SCL_ADDR_RESET;
      rdata    <= 32'h00000000;
    end
    else
    begin
      status <= next_status;
      irq    <= |(next_status & enable);
      rdata  <= rd ? rd_mux : 32'h00000000;
      if (wr_en)
        enable <= wdata[`SCL_EV_W-1:0];
      if (wr_addr)
        dev_addr <= wdata[6:0];
    end

  scl_value_check u_value (
    .clk      (clk),
    .nrst     (nrst),
    .clr      (frame_clr),
    .feed     (arg_feed),
    .ch       (rx_data),
    .is_int   (arg_int),
    .is_float (arg_float),
    .is_sci   (arg_sci),
    .value    (arg_val)
  );

  scl_reply_tx u_reply (
    .clk      (clk),
    .nrst     (nrst),
    .start    (rep_start),
    .kind     (rep_kind),
    .code     (rep_code),
    .addr_hi  (addr_hi),
    .addr_lo  (addr_lo),
    .tx_ready (tx_ready),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .busy     (rep_busy)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_reset_cmd;
    cmd_rst;
  endsequence

  sequence s_no_reply;
    !rep_start ##1 !rep_busy;
  endsequence

  no_parity_a: assert property (s_reset_cmd and pend_par == PAR_NONE |=> link_data8 && !link_par_en) // R01
    else $error("no parity not applied at reset");
  odd_parity_a: assert property (s_reset_cmd and pend_par == PAR_ODD |=> !link_data8 && link_par_en && link_par_odd) // R02
    else $error("odd parity not applied at reset");
  even_parity_a: assert property (s_reset_cmd and pend_par == PAR_EVEN |=> !link_data8 && link_par_en && !link_par_odd) // R03
    else $error("even parity not applied at reset");
  locked_error_a: assert property (do_set && key_req && !armed |=> rep_start && rep_kind == K_LOCKED) // R05
    else $error("locked setting not refused");
  stray_key_a: assert property (comm_settings_key_cmd && !key_req |=> rep_start && rep_kind == K_BAD) // R06
    else $error("key accepted while not required");
  toggle_key_a: assert property (toggle_key_requirement_cmd |=> key_req != $past(key_req) // R07
                                 && rep_kind == (key_req ? K_KEY_ON : K_KEY_OFF))
    else $error("toggle reply mismatch");
  silent_reset_a: assert property (s_reset_cmd |=> s_no_reply) // R09
    else $error("reset command answered");
  deferred_cfg_a: assert property (!soft_rst |=> $stable(link_baud) && $stable(link_data8) && $stable(link_par_odd)) // R10
    else $error("link format changed without reset");
  cause_report_a: assert property (read_shutdown_cause_cmd |=> rep_code == $past(cause) // R11
                                   && cause == $past(cause_ev))
    else $error("cause report or clear wrong");
  cause_sum_a: assert property (emis_fail && !read_shutdown_cause_cmd ##1 !read_shutdown_cause_cmd && !soft_rst // R12
                                |=> (cause & `SCL_CAUSE_EMIS) != 8'h00)
    else $error("emission cause lost");
  ion_cause_a: assert property (ion_fail |=> (cause & `SCL_CAUSE_ION) != 8'h00) // R13
    else $error("ion cause not recorded");
endmodule

// File: src/scl_value_check.sv
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_value_check
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Character stream
  input  wire logic        clr,
  input  wire logic        feed,
  input  wire logic [7:0]  ch,
  // Classification
  output logic             is_int,
  output logic             is_float,
  output logic             is_sci,
  output logic [16:0]      value
);
  logic [2:0] pre;
  logic       sign_seen;
  logic       point;
  logic       post;
  logic       e_seen;
  logic       esign;
  logic       exp_dig;
  logic       bad;
  wire        is_dig  = ch >= `SCL_CH_0 && ch <= `SCL_CH_9;
  wire        is_sgn  = ch == `SCL_CH_PLUS || ch == `SCL_CH_MINUS;
  wire        lead    = pre == 3'h0 && !sign_seen;
  wire        exp_sgn = e_seen && !exp_dig && !esign;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      {pre, sign_seen, point, post, e_seen, esign, exp_dig, bad} <= 10'h000;
      value <= 17'h00000;
    end
    else if (clr)
    begin
      {pre, sign_seen, point, post, e_seen, esign, exp_dig, bad} <= 10'h000;
      value <= 17'h00000;
    end
    else if (feed)
    begin
      if (is_dig && e_seen)
        exp_dig <= 1'b1;
      else if (is_dig && point)
        post <= 1'b1;
      else if (is_dig && pre == `SCL_INT_MAX)
        bad <= 1'b1;
      else if (is_dig)
      begin
        pre   <= 3'(pre + 3'h1);
        value <= 17'(value * `SCL_TEN + {13'h0000, ch[3:0]});
      end
      else if (ch == `SCL_CH_DOT)
        // A digit must stand left of the point
        {point, bad} <= {1'b1, point | e_seen | (pre == 3'h0) | bad}; // R15 R14
      else if (ch == `SCL_CH_E)
        {e_seen, bad} <= {1'b1, e_seen | (pre == 3'h0) | (point & !post) | bad}; // R14
      else if (is_sgn && lead)
        sign_seen <= 1'b1;
      else if (is_sgn && exp_sgn)
        esign <= 1'b1;
      else
        bad <= 1'b1;
    end

  assign is_int   = !bad && pre != 3'h0 && !point && !e_seen && !sign_seen;
  assign is_float = !bad && pre != 3'h0 && point && post && !e_seen; // R14
  assign is_sci   = !bad && pre != 3'h0 && e_seen && exp_dig; // R14
endmodule

// File: tb/scl_host_model.sv
`timescale 1ns/1ps
module scl_host_model
(
  // Clock
  input  wire logic         clk,
  // Command characters
  output logic [7:0]        rx_data,
  output logic              rx_valid,
  // Reply characters
  input  wire logic [7:0]   tx_data,
  input  wire logic         tx_valid,
  output logic              tx_ready,
  // Pacing
  input  wire logic         slow
);
  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end

  // Whole frame per call; key frame sent just before a guarded one
  // Pressure values would always carry a digit before the point
  // Zero bytes are padding wherever they stand and are skipped
  task automatic send(input logic [127:0] s);
    for (int i = 15; i >= 0; i--)
      if (s[i*8 +: 8] != 8'h00)
      begin
        @(posedge clk);
        rx_data  <= s[i*8 +: 8];
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~s[i*8 +: 8];
      end
  endtask

  // Slow pacing halves the sink rate to stall the sender
  task automatic collect(output logic [127:0] r, input int limit);
    int n;
    r = 128'h0;
    n = 0;
    while (n < limit)
    begin
      @(posedge clk);
      n++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
        r = {r[119:0], tx_data};
        if (tx_data === 8'h0D)
          n = limit;
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`include "scl_map.svh"
module tb
  import scl_pkg::*;
;
  logic         clk = 1'b0;
  logic         nrst, rx_valid, tx_valid, tx_ready, slow, wr, rd, irq;
  logic [7:0]   rx_data, tx_data, addr;
  logic         link_data8, link_par_en, link_par_odd;
  scl_baud_t    link_baud;
  logic         ovp_fail, emis_fail, ion_fail;
  logic [31:0]  wdata, rdata;
  logic [127:0] rep;
  wire  [5:0]   fmt = {link_data8, link_par_en, link_par_odd, link_baud};
  logic [39:0]  pcmd [3] = '{{"01", `SCL_MN_ODDPAR}, {"01", `SCL_MN_EVENPAR}, {"01", `SCL_MN_NOPAR}};
  logic [5:0]   pexp [3] = '{{3'b011, BAUD_9600}, {3'b010, BAUD_9600}, {3'b100, BAUD_9600}};
  int           error_cnt = 0;
  int           compares = 0;
  int           cycles = 0;
  localparam logic [127:0] OK = 128'({"*01_", `SCL_TAIL_OK, "\015"});
  localparam logic [127:0] BAD = 128'({"?01_", `SCL_TAIL_BAD, "\015"});
  localparam logic [127:0] LOCKED = 128'({"?01_", `SCL_TAIL_LOCK, "\015"});

  always #50 clk = ~clk;

  scl_top i_scl_top (
    .clk(clk), .nrst(nrst), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .link_data8(link_data8), .link_par_en(link_par_en), .link_par_odd(link_par_odd),
    .link_baud(link_baud), .ovp_fail(ovp_fail), .emis_fail(emis_fail), .ion_fail(ion_fail),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq)
  );

  scl_host_model i_scl_host_model (
    .clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow)
  );

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("Test %s finished, mismatches %0d", name, error_cnt);
  endtask

  task automatic cmd(input logic [95:0] body, input logic [127:0] exp);
    i_scl_host_model.send({"#", body, "\015"});
    i_scl_host_model.collect(rep, 80);
    check(rep, exp);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data lives for one cycle only, so it is taken just after the edge
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(128'(rdata), 128'(exp));
  endtask

  task automatic pulse(input logic o, input logic e, input logic n);
    @(posedge clk);
    {ovp_fail, emis_fail, ion_fail} <= {o, e, n};
    @(posedge clk);
    {ovp_fail, emis_fail, ion_fail} <= 3'b000;
    repeat (3) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      error_cnt++;
      results();
    end
  end

  initial
  begin
    nrst = 1'b0;
    slow = 1'b0;
    {addr, wdata, wr, rd} = '0;
    {ovp_fail, emis_fail, ion_fail} = 3'b000;
    repeat (5) @(posedge clk);
    check(128'(fmt), 128'({3'b100, BAUD_9600}));
    nrst <= 1'b1;
    cmd({"01", `SCL_MN_CAUSE}, "*01_08_POWER\015");
    cmd({"01", `SCL_MN_CAUSE}, "*01_00_ST_OK\015");
    end_test("power cause");
    for (int i = 0; i < 3; i++)
    begin
      cmd(pcmd[i], OK);
      check(128'(fmt), 128'(i == 0 ? {3'b100, BAUD_9600} : pexp[i - 1]));
      cmd("01RST", 128'h0);
      check(128'(fmt), 128'(pexp[i]));
    end
    end_test("parity");
    cmd({"01", `SCL_MN_KEY}, BAD);
    cmd({"01", `SCL_MN_TOGGLE}, 128'({"*01_", `SCL_TAIL_KEYON, "\015"}));
    cmd({"01", `SCL_MN_ODDPAR}, LOCKED);
    cmd({"01", `SCL_MN_BAUD, "19200"}, LOCKED);
    cmd({"01", `SCL_MN_KEY}, OK);
    cmd({"01", `SCL_MN_CAUSE}, "*01_08_POWER\015");
    cmd({"01", `SCL_MN_EVENPAR}, LOCKED);
    slow = 1'b1;
    cmd({"01", `SCL_MN_KEY}, OK);
    cmd({"01", `SCL_MN_BAUD, "19200"}, OK);
    slow = 1'b0;
    check(128'(fmt), 128'({3'b100, BAUD_9600}));
    cmd("01RST", 128'h0);
    check(128'(fmt), 128'({3'b100, BAUD_19200}));
    cmd({"01", `SCL_MN_TOGGLE}, 128'({"*01_", `SCL_TAIL_KEYOFF, "\015"}));
    cmd({"01", `SCL_MN_BAUD, "12345"}, BAD);
    cmd({"02", `SCL_MN_NOPAR}, 128'h0);
    end_test("key");
    wreg(`SCL_OFS_CLEAR, 32'h0000001F);
    wreg(`SCL_OFS_ENABLE, 32'h00000008);
    rchk(`SCL_OFS_STATUS, 32'h00000000);
    check(128'(irq), 128'h0);
    pulse(1'b0, 1'b1, 1'b0);
    check(128'(irq), 128'h1);
    cmd({"01", `SCL_MN_CAUSE}, 128'({"*01_0A_", `SCL_NAME_EMIS, "\015"}));
    pulse(1'b1, 1'b0, 1'b1);
    cmd({"01", `SCL_MN_CAUSE}, "*01_21_ION_C\015");
    cmd({"01", `SCL_MN_CAUSE}, "*01_00_ST_OK\015");
    wreg(`SCL_OFS_ENABLE, 32'h00000000);
    repeat (2) @(posedge clk);
    check(128'(irq), 128'h0);
    wreg(`SCL_OFS_ENABLE, 32'h00000008);
    repeat (2) @(posedge clk);
    check(128'(irq), 128'h1);
    wreg(`SCL_OFS_CLEAR, 32'h00000008);
    repeat (2) @(posedge clk);
    check(128'(irq), 128'h0);
    rchk(`SCL_OFS_STATUS, 32'h00000001);
    end_test("cause and irq");
    rchk(8'h20, 32'h00000000);
    rchk(`SCL_OFS_CONFIG, 32'h00000210);
    rchk(`SCL_OFS_ADDR, 32'h00000001);
    wreg(`SCL_OFS_ADDR, 32'h00000005);
    cmd({"05", `SCL_MN_CAUSE}, "*05_00_ST_OK\015");
    end_test("registers");
    results();
  end
endmodule
